// ---- rtl/dcrl_cfg_if.sv ----
`timescale 1ns/10ps
interface dcrl_cfg_if;
  import dcrl_pkg::*;
  dcrl_mode_t              mode;
  logic                    vco_divided;
  logic                    osc_out_divided;
  logic [3:0]              vco_post_div;
  logic [7:0]              osc_in_div;
  logic [NUM_CHAN*CHAN_W-1:0] chan_div;
  logic [2:0]              fb_sel;
  logic                    doubler;
  logic [1:0]              prediv_code;
  logic [13:0]             r1;
  logic [13:0]             n1;
  logic [11:0]             r2;
  logic [17:0]             ncal;
  logic [2:0]              p_code;
  logic [17:0]             n2;
  logic                    cal_active;

  modport cfg  (output mode, vco_divided, osc_out_divided, vco_post_div, osc_in_div, chan_div, fb_sel,
                doubler, prediv_code, r1, n1, r2, ncal, p_code, n2, cal_active);
  modport calc (input mode, vco_divided, osc_out_divided, vco_post_div, osc_in_div, chan_div, fb_sel,
                doubler, prediv_code, r1, n1, r2, ncal, p_code, n2, cal_active);
endinterface : dcrl_cfg_if

// ---- rtl/dcrl_path_calc.sv ----
`timescale 1ns/10ps
module dcrl_path_calc (
  input  wire logic                     clock,
  input  wire logic                     rst,
  dcrl_cfg_if.calc                      cfg,
  output logic [dcrl_pkg::RATIO_W-1:0]  ref1_total_divide,
  output logic [dcrl_pkg::RATIO_W-1:0]  fb1_total_divide,
  output logic [11:0]                   ref2_divide,
  output logic                          ref2_doubled,
  output logic [dcrl_pkg::RATIO_W-1:0]  fb2_total_divide,
  output logic                          divide_setting_invalid
);
  import dcrl_pkg::*;

  function automatic logic [RATIO_W-1:0] mul3(input logic [RATIO_W-1:0] a, b, c);
    return RATIO_W'(a * b * c);
  endfunction : mul3

  // ----------------------------------------------------------------
  // Path selection
  // ----------------------------------------------------------------
  logic [CHAN_W-1:0]  chan_sel;
  logic [RATIO_W-1:0] vdiv;
  logic [RATIO_W-1:0] vdiv2;
  logic [RATIO_W-1:0] chan_x;
  logic [RATIO_W-1:0] ref1_nxt;
  logic [RATIO_W-1:0] fb1_nxt;
  logic [RATIO_W-1:0] fb2_nxt;
  logic               chan_bad;
  logic               invalid_nxt;

  assign chan_sel = cfg.chan_div[cfg.fb_sel*CHAN_W +: CHAN_W];
  assign vdiv     = cfg.vco_divided ? RATIO_W'(cfg.vco_post_div) : RATIO_W'(1);
  // External VCO modes always pass the post divider
  assign vdiv2    = dcrl_internal(cfg.mode) ? vdiv : RATIO_W'(cfg.vco_post_div);
  assign chan_x   = RATIO_W'(chan_sel);
  assign ref1_nxt = mul3(RATIO_W'(dcrl_prediv(cfg.prediv_code)), RATIO_W'(cfg.r1), RATIO_W'(1));
  // Dual zero delay closes loop one through a channel divider
  assign fb1_nxt  = (cfg.mode == DCRL_DUAL_ZD) ? mul3(vdiv, chan_x, RATIO_W'(cfg.n1)) :
                    mul3(cfg.osc_out_divided ? RATIO_W'(cfg.osc_in_div) : RATIO_W'(1),
                         RATIO_W'(cfg.n1), RATIO_W'(1));
  assign fb2_nxt  = (cfg.cal_active && dcrl_internal(cfg.mode)) ?
                    mul3(vdiv, RATIO_W'(dcrl_prescale(cfg.p_code)), RATIO_W'(cfg.ncal)) :
                    (cfg.mode == DCRL_SINGLE_ZD) ? mul3(vdiv, chan_x, RATIO_W'(cfg.n2)) :
                    mul3(vdiv2, RATIO_W'(dcrl_prescale(cfg.p_code)), RATIO_W'(cfg.n2));

  // Any channel outside the even and odd range flags the setting
  always_comb begin
    chan_bad = 1'b0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (cfg.chan_div[i*CHAN_W +: CHAN_W] < CHAN_MIN || cfg.chan_div[i*CHAN_W +: CHAN_W] > CHAN_MAX) begin
        chan_bad = 1'b1;
      end
    end
  end

  assign invalid_nxt = chan_bad || (cfg.n2 == 18'h00000) || (cfg.r1 == 14'h0000) ||
                       (cfg.n1 == 14'h0000) || (cfg.r2 == 12'h000) ||
                       (dcrl_internal(cfg.mode) && cfg.ncal == 18'h00000);

  // ----------------------------------------------------------------
  // Registered results
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ref1_total_divide      <= '0;
      fb1_total_divide       <= '0;
      ref2_divide            <= '0;
      ref2_doubled           <= 1'b0;
      fb2_total_divide       <= '0;
      divide_setting_invalid <= 1'b0;
    end else begin
      ref1_total_divide      <= ref1_nxt;
      fb1_total_divide       <= fb1_nxt;
      ref2_divide            <= cfg.r2;
      ref2_doubled           <= cfg.doubler;
      fb2_total_divide       <= fb2_nxt;
      divide_setting_invalid <= invalid_nxt;
    end
  end

  a_prescale_zero: assert property (@(posedge clock) disable iff (rst)
    (cfg.p_code == 3'h0 && !cfg.cal_active && cfg.mode == DCRL_DUAL && !cfg.vco_divided)
    |=> fb2_total_divide == RATIO_W'($past(cfg.n2) * 8))
    else $error("prescaler code zero must divide by eight");

  a_cal_uses_ncal: assert property (@(posedge clock) disable iff (rst)
    (cfg.cal_active && dcrl_internal(cfg.mode) && !cfg.vco_divided && cfg.p_code == 3'h4)
    |=> fb2_total_divide == RATIO_W'($past(cfg.ncal) * 4))
    else $error("calibration feedback must use the calibration divider");

endmodule : dcrl_path_calc

// ---- rtl/dcrl_pkg.sv ----
package dcrl_pkg;

  // ----------------------------------------------------------------
  // Frame and register map
  // ----------------------------------------------------------------
  localparam int          FRAME_W     = 32;
  localparam int          ADDR_W      = 5;
  localparam int          NUM_REGS    = 32;
  localparam logic [4:0]  REG_READSEL = 5'h0C;
  localparam logic [4:0]  REG_PRE_R1  = 5'h1B;
  localparam logic [4:0]  REG_R2_N1   = 5'h1C;
  localparam logic [4:0]  REG_CAL     = 5'h1D;
  localparam logic [4:0]  REG_FB2     = 5'h1E;
  localparam logic [4:0]  REG_RBCTL   = 5'h1F;
  localparam logic [31:5] REG_RESET   = 27'h0000000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int N_LSB     = 5;
  localparam int N_MSB     = 22;
  localparam int P_LSB     = 24;
  localparam int P_MSB     = 26;
  localparam int RBLVL_BIT = 21;
  localparam int RBSEL_LSB = 16;
  localparam int RBSEL_MSB = 20;
  localparam int LOCK_BIT  = 5;
  localparam int PRER_LSB  = 20;
  localparam int R1_LSB    = 6;
  localparam int R1_MSB    = 19;
  localparam int R2_LSB    = 20;
  localparam int R2_MSB    = 31;
  localparam int N1_LSB    = 6;
  localparam int N1_MSB    = 19;

  // ----------------------------------------------------------------
  // Divider limits and timing
  // ----------------------------------------------------------------
  localparam int          NUM_CHAN      = 6;
  localparam int          CHAN_W        = 11;
  localparam logic [10:0] CHAN_MIN      = 11'h002;
  localparam logic [10:0] CHAN_MAX      = 11'h415;
  localparam int          RATIO_W       = 40;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          CAL_TIME_NS   = 100000;
  localparam int          CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CAL_CNT_W     = 10;

  typedef enum logic [2:0] {
    DCRL_DUAL, DCRL_DUAL_ZD, DCRL_SINGLE, DCRL_SINGLE_ZD, DCRL_EXT, DCRL_EXT_ZD
  } dcrl_mode_t;

  function automatic logic dcrl_internal(input dcrl_mode_t m);
    return (m != DCRL_EXT) && (m != DCRL_EXT_ZD);
  endfunction : dcrl_internal

  function automatic logic dcrl_reserved(input logic [4:0] a);
    return (a == 5'h09) || ((a >= 5'h10) && (a <= 5'h17));
  endfunction : dcrl_reserved

  // Code 0 gives 8, code 1 duplicates 2
  function automatic logic [3:0] dcrl_prescale(input logic [2:0] c);
    return (c == 3'h0) ? 4'h8 : (c == 3'h1) ? 4'h2 : {1'b0, c};
  endfunction : dcrl_prescale

  function automatic logic [3:0] dcrl_prediv(input logic [1:0] c);
    return 4'(4'h1 << c);
  endfunction : dcrl_prediv

endpackage : dcrl_pkg

// ---- rtl/dcrl_top.sv ----
//------------------------------------------------------------------
//------------------------------------------------------------------
`timescale 1ns/10ps
module dcrl_top (
  input  wire logic                                           clock,
  input  wire logic                                           rst,
  input  wire logic                                           serial_clock_pin,
  input  wire logic                                           serial_data_pin,
  input  wire logic                                           serial_latch_enable_pin,
  output logic                                                readback_data_out,
  input  wire dcrl_pkg::dcrl_mode_t                           operating_mode,
  input  wire logic                                           vco_path_select,
  input  wire logic                                           osc_output_path_select,
  input  wire logic [3:0]                                     vco_post_divider,
  input  wire logic [7:0]                                     osc_input_divider,
  input  wire logic [dcrl_pkg::NUM_CHAN*dcrl_pkg::CHAN_W-1:0] output_channel_divider,
  input  wire logic [2:0]                                     zero_delay_feedback_select,
  input  wire logic                                           ref_doubler_enable,
  input  wire logic [1:0]                                     input_clock_select,
  output logic [dcrl_pkg::RATIO_W-1:0]                        ref1_total_divide,
  output logic [dcrl_pkg::RATIO_W-1:0]                        fb1_total_divide,
  output logic [11:0]                                         ref2_divide,
  output logic                                                ref2_doubled,
  output logic [dcrl_pkg::RATIO_W-1:0]                        fb2_total_divide,
  output logic                                                divide_setting_invalid,
  output logic                                                write_protect_lock,
  output logic                                                readback_strobe_level,
  output logic                                                cal_active,
  output logic                                                sync_event
);
  import dcrl_pkg::*;

  //------------------------------------------------------------------
  // Pin synchronisers
  //------------------------------------------------------------------
  logic       sclk_s1_r;
  logic       sclk_s2_r;
  logic       sclk_s3_r;
  logic       data_s1_r;
  logic       data_s2_r;
  logic       le_s1_r;
  logic       le_s2_r;
  logic       le_s3_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       le_rise;

  // Two stages for data, three for clock and latch; edges are taken only from the second and third
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
      {data_s1_r, data_s2_r}            <= 2'h0;
      {le_s1_r, le_s2_r, le_s3_r}       <= 3'h7; // Idle latch level, so release gives no false commit
    end else begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {serial_clock_pin, sclk_s1_r, sclk_s2_r};
      {data_s1_r, data_s2_r}            <= {serial_data_pin, data_s1_r};
      {le_s1_r, le_s2_r, le_s3_r}       <= {serial_latch_enable_pin, le_s1_r, le_s2_r};
    end
  end

  // Serial clock must stay well below a quarter of the core clock
  assign sclk_rise = sclk_s2_r && !sclk_s3_r;
  assign sclk_fall = !sclk_s2_r && sclk_s3_r;
  assign le_rise   = le_s2_r && !le_s3_r;

  //------------------------------------------------------------------
  // Frame capture
  //------------------------------------------------------------------
  logic [FRAME_W-1:0] shift_r;
  logic [FRAME_W-1:0] shift_nxt;

  // Bits enter MSB first while the latch line is low
  assign shift_nxt = (sclk_rise && !le_s2_r) ? {shift_r[FRAME_W-2:0], data_s2_r} : shift_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  //------------------------------------------------------------------
  // Register array and write protection
  //------------------------------------------------------------------
  logic [31:5]       regs_r [0:NUM_REGS-1];
  logic [ADDR_W-1:0] wr_addr;
  logic [31:5]       wr_data;
  logic              lock_r;
  logic              write_ok;
  logic              do_write;

  assign wr_addr  = shift_r[ADDR_W-1:0];
  assign wr_data  = shift_r[31:5];
  assign lock_r   = regs_r[REG_RBCTL][LOCK_BIT];
  // Register 31 bypasses the lock so software can always unlock
  assign write_ok = (!lock_r || wr_addr == REG_RBCTL) && !dcrl_reserved(wr_addr);
  assign do_write = le_rise && write_ok;

  // Refused frames leave the register array untouched and flag nothing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (do_write) begin
      regs_r[wr_addr] <= wr_data;
    end
  end

  //------------------------------------------------------------------
  // Calibration run and sync event
  //------------------------------------------------------------------
  logic [CAL_CNT_W-1:0] cal_cnt_r;
  logic [CAL_CNT_W-1:0] cal_cnt_nxt;
  logic                 cal_start;
  logic                 sync_nxt;

  // A new write to register 30 restarts a run already in progress
  assign cal_start   = do_write && wr_addr == REG_FB2 && dcrl_internal(operating_mode);
  assign cal_cnt_nxt = cal_start ? CAL_CNT_W'(CAL_CYCLES) :
                       (cal_cnt_r != '0) ? CAL_CNT_W'(cal_cnt_r - 1'b1) : cal_cnt_r;
  assign sync_nxt    = cal_start;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cal_cnt_r  <= '0;
      sync_event <= 1'b0;
    end else begin
      cal_cnt_r  <= cal_cnt_nxt;
      sync_event <= sync_nxt;
    end
  end

  assign cal_active = (cal_cnt_r != '0);

  //------------------------------------------------------------------
  // Readback
  //------------------------------------------------------------------
  logic [ADDR_W-1:0]  rb_sel;
  logic [31:5]        rb_payload;
  logic [FRAME_W-1:0] rb_base;
  logic [FRAME_W-1:0] rb_word;
  logic [FRAME_W-1:0] rb_shift_r;
  logic [FRAME_W-1:0] rb_shift_nxt;
  logic               rb_step;

  assign rb_sel       = regs_r[REG_RBCTL][RBSEL_MSB:RBSEL_LSB];
  assign rb_payload   = regs_r[rb_sel];
  // Reserved codes name no register and return zero
  assign rb_base      = dcrl_reserved(rb_sel) ? '0 : {rb_payload, rb_sel};
  // Register 12 returns its word with the select code placed in bits 20 to 16
  assign rb_word      = (rb_sel == REG_READSEL) ?
                        {rb_base[31:21], rb_sel, rb_base[15:0]} : rb_base;
  assign readback_strobe_level = regs_r[REG_RBCTL][RBLVL_BIT];
  // Shifting is gated only by the strobe level, never by the lock
  assign rb_step      = sclk_fall && (le_s2_r == readback_strobe_level) && !le_rise;
  assign rb_shift_nxt = le_rise ? rb_word :
                        rb_step ? {rb_shift_r[FRAME_W-2:0], 1'b0} : rb_shift_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rb_shift_r <= '0;
    end else begin
      rb_shift_r <= rb_shift_nxt;
    end
  end

  assign readback_data_out  = rb_shift_r[FRAME_W-1];
  assign write_protect_lock = lock_r;

  //------------------------------------------------------------------
  // Divider path calculation
  //------------------------------------------------------------------
  dcrl_cfg_if cfg_bus ();

  assign cfg_bus.mode            = operating_mode;
  assign cfg_bus.vco_divided     = vco_path_select;
  assign cfg_bus.osc_out_divided = osc_output_path_select;
  assign cfg_bus.vco_post_div    = vco_post_divider;
  assign cfg_bus.osc_in_div      = osc_input_divider;
  assign cfg_bus.chan_div        = output_channel_divider;
  assign cfg_bus.fb_sel          = zero_delay_feedback_select;
  assign cfg_bus.doubler         = ref_doubler_enable;
  assign cfg_bus.prediv_code     = regs_r[REG_PRE_R1][PRER_LSB + 2*input_clock_select +: 2];
  assign cfg_bus.r1              = regs_r[REG_PRE_R1][R1_MSB:R1_LSB];
  assign cfg_bus.n1              = regs_r[REG_R2_N1][N1_MSB:N1_LSB];
  assign cfg_bus.r2              = regs_r[REG_R2_N1][R2_MSB:R2_LSB];
  assign cfg_bus.ncal            = regs_r[REG_CAL][N_MSB:N_LSB];
  assign cfg_bus.p_code          = regs_r[REG_FB2][P_MSB:P_LSB];
  assign cfg_bus.n2              = regs_r[REG_FB2][N_MSB:N_LSB];
  assign cfg_bus.cal_active      = cal_active;

  dcrl_path_calc u_calc (
    .clock                  (clock),
    .rst                    (rst),
    .cfg                    (cfg_bus),
    .ref1_total_divide      (ref1_total_divide),
    .fb1_total_divide       (fb1_total_divide),
    .ref2_divide            (ref2_divide),
    .ref2_doubled           (ref2_doubled),
    .fb2_total_divide       (fb2_total_divide),
    .divide_setting_invalid (divide_setting_invalid)
  );

  //------------------------------------------------------------------
  // Checks
  //------------------------------------------------------------------
  a_lock_blocks_write: assert property (@(posedge clock) disable iff (rst)
    (le_rise && lock_r && wr_addr == REG_FB2) |=> $stable(regs_r[REG_FB2]))
    else $error("locked register 30 changed");

  a_unlocked_write: assert property (@(posedge clock) disable iff (rst)
    (le_rise && !lock_r && wr_addr == REG_FB2) |=> regs_r[REG_FB2] == $past(wr_data))
    else $error("unlocked write to register 30 lost");

  a_unlock_path: assert property (@(posedge clock) disable iff (rst)
    (le_rise && wr_addr == REG_RBCTL) |=> lock_r == $past(shift_r[LOCK_BIT]))
    else $error("register 31 write not taken");

  a_lock_sticks: assert property (@(posedge clock) disable iff (rst)
    (lock_r && !(le_rise && wr_addr == REG_RBCTL)) |=> lock_r)
    else $error("lock cleared without register 31 write");

  a_cal_sync: assert property (@(posedge clock) disable iff (rst)
    cal_start |=> (sync_event && cal_active) ##1 !sync_event)
    else $error("calibration start must give one sync pulse");

  a_cal_ext_quiet: assert property (@(posedge clock) disable iff (rst)
    (le_rise && !dcrl_internal(operating_mode)) |=> !sync_event)
    else $error("sync raised in external VCO mode");

  a_rb_select_12: assert property (@(posedge clock) disable iff (rst)
    (le_rise && rb_sel == REG_READSEL) |=> rb_shift_r[20:16] == $past(rb_sel))
    else $error("register 12 readback lacks select value");

  a_rb_hold_level: assert property (@(posedge clock) disable iff (rst)
    (sclk_fall && !le_rise && le_s2_r != readback_strobe_level) |=> $stable(rb_shift_r))
    else $error("readback shifted at wrong strobe level");

  a_rb_shift_locked: assert property (@(posedge clock) disable iff (rst)
    rb_step |=> rb_shift_r == {$past(rb_shift_r[FRAME_W-2:0]), 1'b0})
    else $error("readback failed to shift");

endmodule : dcrl_top

// ---- tb/dcrl_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host controller on the serial programming port
// ----------------------------------------------------------------
module dcrl_host_model (
  input  wire logic clock,
  input  wire logic rb,
  output logic      sclk,
  output logic      sdata,
  output logic      le
);
  // Serial clock starts low and latch sits high outside frames
  initial begin
    sclk  = 1'b0;
    sdata = 1'b0;
    le    = 1'b1;
  end

  // One frame out MSB first; at strobe level low the word loaded at the last commit comes back meanwhile
  task automatic xfer(input logic [31:0] w, output logic [31:0] rd);
    @(posedge clock);
    le <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      sdata <= w[i];
      repeat (3) @(posedge clock);
      sclk <= 1'b1;
      repeat (3) @(posedge clock);
      rd[i] = rb;                               // Taken before the falling edge shifts
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clock);
    sdata <= ~w[0];                             // Released line must not show a stale bit
    le    <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : xfer

  // Readback with the latch left high: clocks only, no frame is built
  task automatic pulse_out(output logic [31:0] rd);
    for (int i = 31; i >= 0; i--) begin
      repeat (3) @(posedge clock);
      sclk <= 1'b1;
      repeat (3) @(posedge clock);
      rd[i] = rb;
      sclk <= 1'b0;
    end
    repeat (3) @(posedge clock);
  endtask : pulse_out
endmodule : dcrl_host_model

// ---- tb/tb_divider_config_readback_lock.sv ----
`timescale 1ns/10ps
module tb_divider_config_readback_lock;
  import dcrl_pkg::*;
  logic clock, rst, serial_clock_pin, serial_data_pin, serial_latch_enable_pin, readback_data_out;
  dcrl_mode_t operating_mode;
  logic vco_path_select, osc_output_path_select, ref_doubler_enable, ref2_doubled, divide_setting_invalid;
  logic [3:0] vco_post_divider;
  logic [7:0] osc_input_divider;
  logic [NUM_CHAN*CHAN_W-1:0] output_channel_divider;
  logic [2:0] zero_delay_feedback_select;
  logic [1:0] input_clock_select;
  logic [RATIO_W-1:0] ref1_total_divide, fb1_total_divide, fb2_total_divide;
  logic [11:0] ref2_divide;
  logic write_protect_lock, readback_strobe_level, cal_active, sync_event;
  logic [31:0] d;
  int mismatches, total_checks, sync_cnt;
  int ptab [8] = '{8, 2, 2, 3, 4, 5, 6, 7};

  dcrl_top dut (.clock, .rst, .serial_clock_pin, .serial_data_pin, .serial_latch_enable_pin,
    .readback_data_out, .operating_mode, .vco_path_select, .osc_output_path_select, .vco_post_divider,
    .osc_input_divider, .output_channel_divider, .zero_delay_feedback_select, .ref_doubler_enable,
    .input_clock_select, .ref1_total_divide, .fb1_total_divide, .ref2_divide, .ref2_doubled,
    .fb2_total_divide, .divide_setting_invalid, .write_protect_lock, .readback_strobe_level,
    .cal_active, .sync_event);
  dcrl_host_model host (.clock(clock), .rb(readback_data_out), .sclk(serial_clock_pin),
    .sdata(serial_data_pin), .le(serial_latch_enable_pin));

  // Clock and a count of synchronisation pulses
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) if (sync_event === 1'b1) sync_cnt <= sync_cnt + 1;

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  function automatic logic [31:0] w31(input logic lvl, input logic [4:0] sel, input logic lk);
    return {10'h000, lvl, sel, 10'h000, lk, 5'h1F};
  endfunction : w31

  // Select, commit once more to load, then shift the word out; address 9 frames are always dropped
  task automatic rd_reg(input logic [4:0] a, input logic lk, output logic [31:0] r);
    logic [31:0] x;
    host.xfer(w31(1'b0, a, lk), x);
    host.xfer(32'h0000_0009, x);
    host.xfer(32'h0000_0009, r);
    @(negedge clock);
  endtask : rd_reg

  // Watchdog sized well above the whole sequence
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    wrap_up();
  end

  initial begin
    rst = 1'b1; sync_cnt = 0; operating_mode = DCRL_DUAL; vco_path_select = 1'b0;
    osc_output_path_select = 1'b0; vco_post_divider = 4'h3; osc_input_divider = 8'h05;
    output_channel_divider = {NUM_CHAN{11'h00A}}; zero_delay_feedback_select = 3'h0;
    ref_doubler_enable = 1'b1; input_clock_select = 2'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(negedge clock);
    check(write_protect_lock, 0);
    host.xfer({6'h00, 4'h0, 2'h2, 14'h0003, 1'b0, 5'h1B}, d);
    host.xfer({12'h002, 14'h0007, 1'b0, 5'h1C}, d);
    host.xfer({9'h000, 18'h00005, 5'h1D}, d);
    // Every prescaler code during calibration, last one code 0 with full divider
    for (int c = 7; c >= 0; c--) begin
      host.xfer({5'h00, 3'(c), 1'b0, 18'h3FFFF, 5'h1E}, d);
      @(negedge clock);
      check(cal_active, 1);
      check(fb2_total_divide, 40'(ptab[c] * 5));
    end
    check(40'(sync_cnt), 8);
    check(ref1_total_divide, 12);
    check(fb1_total_divide, 7);
    check({ref2_doubled, ref2_divide}, 13'h1002);
    check(divide_setting_invalid, 0);
    @(posedge clock);
    osc_output_path_select <= 1'b1;
    input_clock_select     <= 2'h1;
    ref_doubler_enable     <= 1'b0;
    repeat (4) @(negedge clock);
    check(fb1_total_divide, 35);
    check(ref1_total_divide, 3);
    check({ref2_doubled, ref2_divide}, 13'h0002);
    @(posedge clock);
    output_channel_divider[10:0] <= 11'h416;
    repeat (4) @(negedge clock);
    check(divide_setting_invalid, 1);
    @(posedge clock);
    operating_mode <= DCRL_DUAL_ZD;
    output_channel_divider[10:0] <= 11'h415;
    repeat (4) @(negedge clock);
    check(divide_setting_invalid, 0);
    check(fb1_total_divide, 40'h0000001C93);
    @(posedge clock);
    operating_mode <= DCRL_DUAL;
    repeat (1010) @(negedge clock);
    check(cal_active, 0);
    check(fb2_total_divide, 40'h00001FFFF8);
    @(posedge clock);
    vco_path_select <= 1'b1;
    repeat (4) @(negedge clock);
    check(fb2_total_divide, 40'h00005FFFE8);
    @(posedge clock);
    operating_mode <= DCRL_SINGLE_ZD;
    repeat (4) @(negedge clock);
    check(fb2_total_divide, 40'h0030FBF3C1);
    @(posedge clock);
    operating_mode <= DCRL_DUAL;
    rd_reg(5'h1E, 1'b1, d);
    check(d, 32'h007FFFFE);
    check(write_protect_lock, 1);
    host.xfer({5'h00, 3'h2, 1'b0, 18'h00001, 5'h1E}, d);
    check(40'(sync_cnt), 8);
    rd_reg(5'h1E, 1'b1, d);
    check(d, 32'h007FFFFE);
    rd_reg(5'h1F, 1'b1, d);
    check(d[5], 1);
    rd_reg(5'h1E, 1'b0, d);
    check(d, 32'h007FFFFE);
    host.xfer({5'h00, 3'h2, 1'b0, 18'h00001, 5'h1E}, d);
    check(40'(sync_cnt), 9);
    // External VCO: no calibration, post divider always in the loop
    @(posedge clock);
    operating_mode  <= DCRL_EXT;
    vco_path_select <= 1'b0;
    host.xfer({5'h00, 3'h3, 1'b0, 18'h00002, 5'h1E}, d);
    @(negedge clock);
    check(40'(sync_cnt), 9);
    check(fb2_total_divide, 18);
    rd_reg(5'h0C, 1'b0, d);
    rd_reg(5'h0C, 1'b0, d);
    check(d[20:16], 5'h0C);
    rd_reg(5'h09, 1'b0, d);
    rd_reg(5'h09, 1'b0, d);
    check(d, 0);
    host.xfer(w31(1'b1, 5'h1F, 1'b0), d);
    @(negedge clock);
    check(readback_strobe_level, 1);
    // Latch low no longer shifts; latch high does
    host.xfer(32'h0000_0009, d);
    host.xfer(32'h0000_0009, d);
    check(d, 0);
    host.pulse_out(d);
    check(d, 32'h003F001F);
    wrap_up();
  end
endmodule : tb_divider_config_readback_lock
